// File: rtl/io_register_space_decoder.sv
// Address decoder and register bank for the I/O register space of the core.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Bit set and clear on addresses 0x00-0x1F.
// - Bit test gives skip decision there.
// - Writing one clears a flag; zero keeps.
// - Bit operations touch only the addressed bit.
// - Short I/O access covers addresses 0x00-0x3F.
// - Data-space address equals I/O address plus 0x20.
// - Extended window reachable only by load/store.
// - Exactly 64 short locations; rest extended.
module io_register_space_decoder (
   input  wire  logic       mclk,
   input  wire  logic       sys_rst,
   input  wire  logic [2:0] access_kind,
   input  wire  logic [7:0] access_addr,
   input  wire  logic [2:0] bit_select,
   input  wire  logic [7:0] write_data,
   input  wire  logic [7:0] port_b_pins,
   input  wire  logic [7:0] port_c_pins,
   input  wire  logic [7:0] port_d_pins,
   input  wire  logic [7:0] timer0_events,
   input  wire  logic [7:0] timer1_events,
   input  wire  logic [7:0] timer2_events,
   input  wire  logic [7:0] pin_change_events,
   input  wire  logic [7:0] external_irq_events,
   input  wire  logic [7:0] spi_status_in,
   input  wire  logic [7:0] ext_read_data,
   output logic [7:0]       read_data,
   output logic             read_valid,
   output logic             skip_next,
   output logic             skip_valid,
   output logic             ext_write_strobe,
   output logic             ext_read_strobe,
   output logic [7:0]       ext_addr,
   output logic [7:0]       ext_write_data,
   output logic [63:0]      reg_write_strobe,
   output logic [7:0]       port_b_direction,
   output logic [7:0]       port_b_output,
   output logic [7:0]       port_c_direction,
   output logic [7:0]       port_c_output,
   output logic [7:0]       port_d_direction,
   output logic [7:0]       port_d_output,
   output logic [7:0]       timer0_flags,
   output logic [7:0]       timer1_flags,
   output logic [7:0]       timer2_flags,
   output logic [7:0]       pin_change_flags,
   output logic [7:0]       external_irq_flags,
   output logic [7:0]       external_irq_mask,
   output logic [7:0]       nvm_data_control,
   output logic [7:0]       timer_prescaler_control,
   output logic [7:0]       timer0_control_a,
   output logic [7:0]       timer0_control_b
);

   // ----------------------------------------
   // Input synchronisers for pins
   // ----------------------------------------
   logic [7:0] pin_b_meta_reg;
   logic [7:0] pin_b_sync_reg;
   logic [7:0] pin_c_meta_reg;
   logic [7:0] pin_c_sync_reg;
   logic [7:0] pin_d_meta_reg;
   logic [7:0] pin_d_sync_reg;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pin_b_meta_reg <= 8'h00;
         pin_b_sync_reg <= 8'h00;
         pin_c_meta_reg <= 8'h00;
         pin_c_sync_reg <= 8'h00;
         pin_d_meta_reg <= 8'h00;
         pin_d_sync_reg <= 8'h00;
      end else begin
         pin_b_meta_reg <= port_b_pins;
         pin_b_sync_reg <= pin_b_meta_reg;
         pin_c_meta_reg <= port_c_pins;
         pin_c_sync_reg <= pin_c_meta_reg;
         pin_d_meta_reg <= port_d_pins;
         pin_d_sync_reg <= pin_d_meta_reg;
      end
   end

   // ----------------------------------------
   // Address translation
   // ----------------------------------------
   io_space_pkg::access_kind_t kind;
   assign kind = io_space_pkg::access_kind_t'(access_kind);

   wire is_short  = (kind == io_space_pkg::acc_io_read) || (kind == io_space_pkg::acc_io_write);
   wire is_mem    = (kind == io_space_pkg::acc_mem_read) || (kind == io_space_pkg::acc_mem_write);
   wire is_bitop  = (kind == io_space_pkg::acc_bit_set) || (kind == io_space_pkg::acc_bit_clear)
                    || (kind == io_space_pkg::acc_bit_test);
   wire is_rd     = (kind == io_space_pkg::acc_io_read) || (kind == io_space_pkg::acc_mem_read);
   wire is_wr     = (kind == io_space_pkg::acc_io_write) || (kind == io_space_pkg::acc_mem_write);

   // Short instructions carry only a six-bit field, so the upper bits are ignored.
   wire [7:0] short_addr    = {2'b00, access_addr[5:0]};
   wire       short_in_rng  = short_addr <= io_space_pkg::short_io_last;
   wire [7:0] mem_io_addr   = access_addr - io_space_pkg::data_space_shift;
   wire       mem_hits_io   = (access_addr >= io_space_pkg::data_space_shift)
                              && (mem_io_addr <= io_space_pkg::short_io_last);
   wire       mem_hits_ext  = (access_addr >= io_space_pkg::ext_io_first)
                              && (access_addr <= io_space_pkg::ext_io_last);
   wire       bit_in_rng    = short_addr <= io_space_pkg::bit_io_last;

   wire       io_hit  = (is_short && short_in_rng) || (is_mem && mem_hits_io)
                        || (is_bitop && bit_in_rng);
   wire [5:0] io_addr = is_mem ? mem_io_addr[5:0] : short_addr[5:0];

   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   wire [63:0] addr_onehot = 64'h0000_0000_0000_0001 << io_addr;

   wire sel_pin_b   = io_addr == io_space_pkg::port_b_pin_input_addr;
   wire sel_pin_c   = io_addr == io_space_pkg::port_c_pin_input_addr;
   wire sel_pin_d   = io_addr == io_space_pkg::port_d_pin_input_addr;
   wire sel_t0f     = io_addr == io_space_pkg::timer0_flags_addr;
   wire sel_t1f     = io_addr == io_space_pkg::timer1_flags_addr;
   wire sel_t2f     = io_addr == io_space_pkg::timer2_flags_addr;
   wire sel_pcf     = io_addr == io_space_pkg::pin_change_flags_addr;
   wire sel_eif     = io_addr == io_space_pkg::external_irq_flags_addr;
   wire sel_serial_periph_status    = io_addr == io_space_pkg::serial_periph_status_addr;

   // Writable mask per I/O address; zero marks reserved, read-only or flag locations.
   logic [7:0] wr_mask_of;
   always_comb begin
      wr_mask_of = 8'h00;
      if (io_addr == io_space_pkg::port_b_direction_addr ||
          io_addr == io_space_pkg::port_b_output_addr ||
          io_addr == io_space_pkg::port_d_direction_addr ||
          io_addr == io_space_pkg::port_d_output_addr ||
          io_addr == io_space_pkg::general_purpose_0_addr ||
          io_addr == io_space_pkg::general_purpose_1_addr ||
          io_addr == io_space_pkg::general_purpose_2_addr ||
          io_addr == io_space_pkg::nvm_data_byte_addr ||
          io_addr == io_space_pkg::nvm_address_low_addr ||
          io_addr == io_space_pkg::nvm_address_high_addr ||
          io_addr == io_space_pkg::timer0_count_addr ||
          io_addr == io_space_pkg::timer0_compare_a_addr ||
          io_addr == io_space_pkg::timer0_compare_b_addr ||
          io_addr == io_space_pkg::serial_periph_control_addr) begin
         wr_mask_of = 8'hff;
      end else if (io_addr == io_space_pkg::port_c_direction_addr ||
                   io_addr == io_space_pkg::port_c_output_addr) begin
         wr_mask_of = io_space_pkg::port_c_bits_mask;
      end else if (io_addr == io_space_pkg::external_irq_mask_addr) begin
         wr_mask_of = io_space_pkg::external_irq_mask_bits;
      end else if (io_addr == io_space_pkg::nvm_data_control_addr) begin
         wr_mask_of = io_space_pkg::nvm_control_mask;
      end else if (io_addr == io_space_pkg::timer_prescaler_control_addr) begin
         wr_mask_of = io_space_pkg::prescaler_ctrl_mask;
      end else if (io_addr == io_space_pkg::timer0_control_a_addr) begin
         wr_mask_of = io_space_pkg::timer0_ctrl_a_mask;
      end else if (io_addr == io_space_pkg::timer0_control_b_addr) begin
         wr_mask_of = io_space_pkg::timer0_ctrl_b_mask;
      end else if (io_addr == io_space_pkg::serial_periph_status_addr) begin
         wr_mask_of = io_space_pkg::spi_status_wr_mask;
      end
   end

   wire sel_flag = sel_t0f || sel_t1f || sel_t2f || sel_pcf || sel_eif;
   wire [7:0] bit_onehot = 8'h01 << bit_select;

   // Bit operations are masked to one bit, so no neighbour is written back.
   wire       bit_set  = (kind == io_space_pkg::acc_bit_set) && io_hit;
   wire       bit_clr  = (kind == io_space_pkg::acc_bit_clear) && io_hit;
   wire       any_wr   = (is_wr || bit_set || bit_clr) && io_hit;
   wire [7:0] op_mask  = (bit_set || bit_clr) ? bit_onehot : 8'hff;
   wire [7:0] op_data  = bit_set ? 8'hff : (bit_clr ? 8'h00 : write_data);

   // Reserved or read-only addresses get no strobe and the write is dropped.
   wire [7:0]  arr_mask   = wr_mask_of & op_mask;
   wire [63:0] arr_strobe = (any_wr && !sel_flag && (wr_mask_of != 8'h00))
                            ? addr_onehot : 64'h0;
   wire [7:0]  clr_pulse  = (any_wr && sel_flag) ? (op_data & op_mask) : 8'h00;

   // ----------------------------------------
   // Storage for plain read/write registers
   // ----------------------------------------
   logic [7:0]   arr_rd_data;
   logic [511:0] arr_flat;

   io_reg_array u_regs (
      .mclk        (mclk),
      .sys_rst     (sys_rst),
      .wr_strobe   (arr_strobe),
      .wr_bit_mask (arr_mask),
      .wr_data     (op_data),
      .rd_addr     (io_addr),
      .rd_data     (arr_rd_data),
      .flat_regs   (arr_flat)
   );

   // ----------------------------------------
   // Write-one-to-clear flag registers
   // ----------------------------------------
   logic [7:0] t0f_reg;
   logic [7:0] t1f_reg;
   logic [7:0] t2f_reg;
   logic [7:0] pcf_reg;
   logic [7:0] eif_reg;

   // A new event in the clearing cycle wins over the clear.
   wire [7:0] t0f_next = ((t0f_reg & ~(sel_t0f ? clr_pulse : 8'h00)) | timer0_events)
                         & io_space_pkg::timer0_flags_mask;
   wire [7:0] t1f_next = ((t1f_reg & ~(sel_t1f ? clr_pulse : 8'h00)) | timer1_events)
                         & io_space_pkg::timer1_flags_mask;
   wire [7:0] t2f_next = ((t2f_reg & ~(sel_t2f ? clr_pulse : 8'h00)) | timer2_events)
                         & io_space_pkg::timer2_flags_mask;
   wire [7:0] pcf_next = ((pcf_reg & ~(sel_pcf ? clr_pulse : 8'h00)) | pin_change_events)
                         & io_space_pkg::pin_change_flags_mask;
   wire [7:0] eif_next = ((eif_reg & ~(sel_eif ? clr_pulse : 8'h00)) | external_irq_events)
                         & io_space_pkg::external_irq_mask_bits;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         t0f_reg <= io_space_pkg::reg_reset_value;
         t1f_reg <= io_space_pkg::reg_reset_value;
         t2f_reg <= io_space_pkg::reg_reset_value;
         pcf_reg <= io_space_pkg::reg_reset_value;
         eif_reg <= io_space_pkg::reg_reset_value;
      end else begin
         t0f_reg <= t0f_next;
         t1f_reg <= t1f_next;
         t2f_reg <= t2f_next;
         pcf_reg <= pcf_next;
         eif_reg <= eif_next;
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   logic [7:0] live_rd_reg;
   logic       use_live_reg;
   logic       io_rd_reg;
   logic       ext_rd_reg;
   logic [2:0] bit_sel_reg;
   logic       test_reg;

   wire io_rd_now  = (is_rd || (kind == io_space_pkg::acc_bit_test)) && io_hit;
   wire ext_rd_now = (kind == io_space_pkg::acc_mem_read) && mem_hits_ext;
   wire ext_wr_now = (kind == io_space_pkg::acc_mem_write) && mem_hits_ext;

   logic [7:0] live_value;
   always_comb begin
      live_value = 8'h00;
      if (sel_pin_b) begin
         live_value = pin_b_sync_reg;
      end else if (sel_pin_c) begin
         live_value = pin_c_sync_reg & io_space_pkg::port_c_bits_mask;
      end else if (sel_pin_d) begin
         live_value = pin_d_sync_reg;
      end else if (sel_t0f) begin
         live_value = t0f_reg;
      end else if (sel_t1f) begin
         live_value = t1f_reg;
      end else if (sel_t2f) begin
         live_value = t2f_reg;
      end else if (sel_pcf) begin
         live_value = pcf_reg;
      end else if (sel_eif) begin
         live_value = eif_reg;
      end else if (sel_serial_periph_status) begin
         live_value = (spi_status_in & io_space_pkg::spi_status_ro_mask)
                      | (arr_flat[io_space_pkg::serial_periph_status_addr*8 +: 8]
                         & io_space_pkg::spi_status_wr_mask);
      end
   end

   wire live_sel = sel_pin_b || sel_pin_c || sel_pin_d || sel_flag || sel_serial_periph_status;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         live_rd_reg  <= 8'h00;
         use_live_reg <= 1'b0;
         io_rd_reg    <= 1'b0;
         ext_rd_reg   <= 1'b0;
         bit_sel_reg  <= 3'b000;
         test_reg     <= 1'b0;
      end else begin
         live_rd_reg  <= live_value;
         use_live_reg <= live_sel;
         io_rd_reg    <= io_rd_now;
         ext_rd_reg   <= ext_rd_now;
         bit_sel_reg  <= bit_select;
         test_reg     <= (kind == io_space_pkg::acc_bit_test) && io_hit;
      end
   end

   // Unmapped array cells hold zero since they never get a strobe.
   wire [7:0] io_value = use_live_reg ? live_rd_reg : arr_rd_data;
   wire [7:0] rd_value = io_rd_reg ? io_value : (ext_rd_reg ? ext_read_data : 8'h00);

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         read_data        <= 8'h00;
         read_valid       <= 1'b0;
         skip_next        <= 1'b0;
         skip_valid       <= 1'b0;
         ext_write_strobe <= 1'b0;
         ext_read_strobe  <= 1'b0;
         ext_addr         <= 8'h00;
         ext_write_data   <= 8'h00;
         reg_write_strobe <= 64'h0;
      end else begin
         read_data        <= rd_value;
         read_valid       <= io_rd_reg || ext_rd_reg;
         // Skip when the tested bit is set; a skip-if-clear caller inverts it.
         skip_next        <= test_reg && io_value[bit_sel_reg];
         skip_valid       <= test_reg;
         ext_write_strobe <= ext_wr_now;
         ext_read_strobe  <= ext_rd_now;
         ext_addr         <= access_addr;
         ext_write_data   <= write_data;
         reg_write_strobe <= arr_strobe | (sel_flag && any_wr ? addr_onehot : 64'h0);
      end
   end

   // ----------------------------------------
   // Register views driven out
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         port_b_direction        <= 8'h00;
         port_b_output           <= 8'h00;
         port_c_direction        <= 8'h00;
         port_c_output           <= 8'h00;
         port_d_direction        <= 8'h00;
         port_d_output           <= 8'h00;
         timer0_flags            <= 8'h00;
         timer1_flags            <= 8'h00;
         timer2_flags            <= 8'h00;
         pin_change_flags        <= 8'h00;
         external_irq_flags      <= 8'h00;
         external_irq_mask       <= 8'h00;
         nvm_data_control        <= 8'h00;
         timer_prescaler_control <= 8'h00;
         timer0_control_a        <= 8'h00;
         timer0_control_b        <= 8'h00;
      end else begin
         port_b_direction        <= arr_flat[io_space_pkg::port_b_direction_addr*8 +: 8];
         port_b_output           <= arr_flat[io_space_pkg::port_b_output_addr*8 +: 8];
         port_c_direction        <= arr_flat[io_space_pkg::port_c_direction_addr*8 +: 8];
         port_c_output           <= arr_flat[io_space_pkg::port_c_output_addr*8 +: 8];
         port_d_direction        <= arr_flat[io_space_pkg::port_d_direction_addr*8 +: 8];
         port_d_output           <= arr_flat[io_space_pkg::port_d_output_addr*8 +: 8];
         timer0_flags            <= t0f_reg;
         timer1_flags            <= t1f_reg;
         timer2_flags            <= t2f_reg;
         pin_change_flags        <= pcf_reg;
         external_irq_flags      <= eif_reg;
         external_irq_mask       <= arr_flat[io_space_pkg::external_irq_mask_addr*8 +: 8];
         nvm_data_control        <= arr_flat[io_space_pkg::nvm_data_control_addr*8 +: 8];
         timer_prescaler_control <= arr_flat[io_space_pkg::timer_prescaler_control_addr*8 +: 8];
         timer0_control_a        <= arr_flat[io_space_pkg::timer0_control_a_addr*8 +: 8];
         timer0_control_b        <= arr_flat[io_space_pkg::timer0_control_b_addr*8 +: 8];
      end
   end

endmodule

`default_nettype wire

// File: rtl/io_space_pkg.sv
// Package with the address map, field layouts and reset values of the I/O register space.
package io_space_pkg;

   // ----------------------------------------
   // Address windows
   // ----------------------------------------
   localparam logic [7:0] short_io_last    = 8'h3f;
   localparam logic [7:0] bit_io_last      = 8'h1f;
   localparam logic [7:0] data_space_shift = 8'h20;
   localparam logic [7:0] ext_io_first     = 8'h60;
   localparam logic [7:0] ext_io_last      = 8'hff;
   localparam int         short_io_count   = 64;

   // ----------------------------------------
   // Register offsets (I/O addresses)
   // ----------------------------------------
   localparam logic [5:0] port_b_pin_input_addr        = 6'h03;
   localparam logic [5:0] port_b_direction_addr        = 6'h04;
   localparam logic [5:0] port_b_output_addr           = 6'h05;
   localparam logic [5:0] port_c_pin_input_addr        = 6'h06;
   localparam logic [5:0] port_c_direction_addr        = 6'h07;
   localparam logic [5:0] port_c_output_addr           = 6'h08;
   localparam logic [5:0] port_d_pin_input_addr        = 6'h09;
   localparam logic [5:0] port_d_direction_addr        = 6'h0a;
   localparam logic [5:0] port_d_output_addr           = 6'h0b;
   localparam logic [5:0] timer0_flags_addr            = 6'h15;
   localparam logic [5:0] timer1_flags_addr            = 6'h16;
   localparam logic [5:0] timer2_flags_addr            = 6'h17;
   localparam logic [5:0] pin_change_flags_addr        = 6'h1b;
   localparam logic [5:0] external_irq_flags_addr      = 6'h1c;
   localparam logic [5:0] external_irq_mask_addr       = 6'h1d;
   localparam logic [5:0] general_purpose_0_addr       = 6'h1e;
   localparam logic [5:0] nvm_data_control_addr        = 6'h1f;
   localparam logic [5:0] nvm_data_byte_addr           = 6'h20;
   localparam logic [5:0] nvm_address_low_addr         = 6'h21;
   localparam logic [5:0] nvm_address_high_addr        = 6'h22;
   localparam logic [5:0] timer_prescaler_control_addr = 6'h23;
   localparam logic [5:0] timer0_control_a_addr        = 6'h24;
   localparam logic [5:0] timer0_control_b_addr        = 6'h25;
   localparam logic [5:0] timer0_count_addr            = 6'h26;
   localparam logic [5:0] timer0_compare_a_addr        = 6'h27;
   localparam logic [5:0] timer0_compare_b_addr        = 6'h28;
   localparam logic [5:0] general_purpose_1_addr       = 6'h2a;
   localparam logic [5:0] general_purpose_2_addr       = 6'h2b;
   localparam logic [5:0] serial_periph_control_addr   = 6'h2c;
   localparam logic [5:0] serial_periph_status_addr    = 6'h2d;

   // ----------------------------------------
   // Implemented bits per register
   // ----------------------------------------
   localparam logic [7:0] port_c_bits_mask       = 8'h7f;
   localparam logic [7:0] timer0_flags_mask      = 8'h07;
   localparam logic [7:0] timer1_flags_mask      = 8'h27;
   localparam logic [7:0] timer2_flags_mask      = 8'h07;
   localparam logic [7:0] pin_change_flags_mask  = 8'h07;
   localparam logic [7:0] external_irq_mask_bits = 8'h03;
   localparam logic [7:0] nvm_control_mask       = 8'h3f;
   localparam logic [7:0] prescaler_ctrl_mask    = 8'h83;
   localparam logic [7:0] timer0_ctrl_a_mask     = 8'hf3;
   localparam logic [7:0] timer0_ctrl_b_mask     = 8'hcf;
   localparam logic [7:0] spi_status_wr_mask     = 8'h01;
   localparam logic [7:0] spi_status_ro_mask     = 8'hc0;
   localparam logic [7:0] reg_reset_value        = 8'h00;

   // ----------------------------------------
   // Access kinds issued by the core
   // ----------------------------------------
   typedef enum logic [2:0] {
      acc_none      = 3'b000,
      acc_io_read   = 3'b001,
      acc_io_write  = 3'b010,
      acc_mem_read  = 3'b011,
      acc_mem_write = 3'b100,
      acc_bit_set   = 3'b101,
      acc_bit_clear = 3'b110,
      acc_bit_test  = 3'b111
   } access_kind_t;

endpackage

// File: rtl/io_reg_array.sv
// Small register memory for the 64 short I/O locations with registered read data.
`timescale 1ns/1ps
`default_nettype none

module io_reg_array (
   input  wire  logic       mclk,
   input  wire  logic       sys_rst,
   input  wire  logic [63:0] wr_strobe,
   input  wire  logic [7:0] wr_bit_mask,
   input  wire  logic [7:0] wr_data,
   input  wire  logic [5:0] rd_addr,
   output logic [7:0]       rd_data,
   output logic [511:0]     flat_regs
);

   logic [7:0] cell_reg [0:63];

   genvar g;
   generate
      for (g = 0; g < 64; g++) begin : g_cell
         always_ff @(posedge mclk) begin
            if (sys_rst) begin
               cell_reg[g] <= io_space_pkg::reg_reset_value;
            end else if (wr_strobe[g]) begin
               cell_reg[g] <= (cell_reg[g] & ~wr_bit_mask) | (wr_data & wr_bit_mask);
            end
         end
         assign flat_regs[g*8 +: 8] = cell_reg[g];
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rd_data <= io_space_pkg::reg_reset_value;
      end else begin
         rd_data <= cell_reg[rd_addr];
      end
   end

endmodule

`default_nettype wire

// File: dv/io_space_checker_properties.sv
// Checker of decoder answer timing and address windows.
`timescale 1ns/1ps
`default_nettype none
module io_space_checker (
   input wire logic        mclk, sys_rst, read_valid, skip_valid,
   input wire logic        ext_read_strobe, ext_write_strobe,
   input wire logic [2:0]  access_kind,
   input wire logic [7:0]  access_addr, ext_addr,
   input wire logic [63:0] reg_write_strobe
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   sequence bit_low; access_kind == 3'h7 && access_addr[5:0] <= 6'h1f; endsequence
   sequence bit_high; access_kind > 3'h4 && access_addr[5:0] > 6'h1f; endsequence
   chk_io_strobe: assert property (
      access_kind == 3'h2 && access_addr == 8'h05 |=> reg_write_strobe == 64'h20) else $error("strobe");
   chk_drop_write: assert property (
      access_kind == 3'h2 && access_addr <= 8'h03 |=> reg_write_strobe == 64'h0) else $error("dropped");
   chk_mem_offset: assert property (
      access_kind == 3'h4 && access_addr == 8'h25 |=> reg_write_strobe == 64'h20) else $error("offset");
   chk_read_answer: assert property (
      access_kind == 3'h1 |-> ##2 read_valid) else $error("read answer");
   chk_mem_low: assert property (
      access_kind == 3'h3 && access_addr < 8'h20 |-> ##2 !read_valid) else $error("low window");
   chk_ext_source: assert property (
      ext_read_strobe |-> $past(access_kind) == 3'h3 && $past(access_addr) >= 8'h60) else $error("ext");
   chk_ext_write: assert property (
      access_kind == 3'h4 && access_addr >= 8'h60 |=> ext_write_strobe) else $error("ext write");
   chk_skip_answer: assert property (
      bit_low |-> ##2 skip_valid) else $error("skip answer");
   chk_bit_window: assert property (
      bit_high |=> reg_write_strobe == 64'h0 ##1 !skip_valid) else $error("bit window");
   chk_ext_addr: assert property (
      ext_write_strobe || ext_read_strobe |-> ext_addr >= 8'h60) else $error("ext addr");
endmodule
bind io_register_space_decoder io_space_checker chk (.mclk(mclk), .sys_rst(sys_rst),
   .read_valid(read_valid), .skip_valid(skip_valid), .ext_read_strobe(ext_read_strobe),
   .ext_write_strobe(ext_write_strobe), .access_kind(access_kind), .access_addr(access_addr),
   .ext_addr(ext_addr), .reg_write_strobe(reg_write_strobe));
`default_nettype wire

// File: dv/ext_space_model.sv
// Behavioural model of the extended register window behind the decoder.
`timescale 1ns/1ps
`default_nettype none
module ext_space_model (
   input wire logic       mclk, ext_write_strobe, ext_read_strobe,
   input wire logic [7:0] ext_addr, ext_write_data,
   output logic [7:0]     ext_read_data
);
   logic [7:0] mem [256] = '{default: 8'h00};
   always @(posedge mclk) if (ext_write_strobe) mem[ext_addr] <= ext_write_data;
   // Outside a read strobe the bus shows the inverse, so a late sample is noticed.
   assign ext_read_data = ext_read_strobe ? mem[ext_addr] : ~mem[ext_addr];
endmodule
`default_nettype wire

// File: dv/io_register_space_decoder_tb_top.sv
// Testbench issuing core accesses into the I/O register space decoder.
`timescale 1ns/1ps
`default_nettype none
module io_register_space_decoder_tb_top;
   logic       mclk = 1'b0, sys_rst = 1'b1, rv, sn, sv, ews, ers;
   logic [2:0] kind = 3'h0, bsel = 3'h0;
   logic [7:0] addr = 8'h00, wdat = 8'h00, pins = 8'ha5, ev = 8'h00, rdat, ea, ewd, erd, pdo, pbo, t0f;
   int         bad_count = 0, checks = 0;
   always #4 mclk = ~mclk;
   io_register_space_decoder DUT (.mclk(mclk), .sys_rst(sys_rst), .access_kind(kind),
      .access_addr(addr), .bit_select(bsel), .write_data(wdat), .port_b_pins(pins),
      .port_c_pins(pins), .port_d_pins(pins), .timer0_events(ev), .timer1_events(ev),
      .timer2_events(ev), .pin_change_events(ev), .external_irq_events(ev),
      .spi_status_in(ev), .ext_read_data(erd), .read_data(rdat), .read_valid(rv),
      .skip_next(sn), .skip_valid(sv), .ext_write_strobe(ews), .ext_read_strobe(ers),
      .ext_addr(ea), .ext_write_data(ewd), .reg_write_strobe(), .port_b_direction(),
      .port_b_output(pbo), .port_c_direction(), .port_c_output(), .port_d_direction(),
      .port_d_output(pdo), .timer0_flags(t0f), .timer1_flags(), .timer2_flags(),
      .pin_change_flags(), .external_irq_flags(), .external_irq_mask(),
      .nvm_data_control(), .timer_prescaler_control(), .timer0_control_a(),
      .timer0_control_b());
   ext_space_model partner (.mclk(mclk), .ext_write_strobe(ews), .ext_read_strobe(ers),
      .ext_addr(ea), .ext_write_data(ewd), .ext_read_data(erd));
   task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, e, g);
      end
   endtask
   // One request cycle, then return in the cycle where its answer stands.
   task automatic acc(input logic [2:0] k, input logic [7:0] a, input logic [2:0] b,
                      input logic [7:0] d);
      kind = k; addr = a; bsel = b; wdat = d;
      @(negedge mclk) kind = 3'h0;
      @(negedge mclk);
   endtask
   task automatic rd(input logic [2:0] k, input logic [7:0] a, input logic [7:0] e);
      acc(k, a, 3'h0, 8'h00);
      cmp("read_data", e, rdat);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (3) @(negedge mclk);
      sys_rst = 1'b0;
      for (int i = 0; i < 64; i++)
         rd(3'h1, 8'(i), (i == 3 || i == 9) ? pins : (i == 6) ? (pins & 8'h7f) :
            io_space_pkg::reg_reset_value);
      acc(3'h4, 8'h25, 3'h0, 8'h5a);
      rd(3'h1, 8'h05, 8'h5a);
      cmp("port_b_output", 8'h5a, pbo);
      acc(3'h2, 8'h03, 3'h0, 8'h3c);
      rd(3'h1, 8'h02, 8'h00);
      acc(3'h2, 8'h03, 3'h0, 8'h00);
      rd(3'h3, 8'h23, pins);
      rd(3'h3, 8'h10, 8'h00);
      $display("test windows ended");
      ev = 8'hff;
      @(negedge mclk) ev = 8'h00;
      rd(3'h1, 8'h15, io_space_pkg::timer0_flags_mask);
      acc(3'h2, 8'h15, 3'h0, 8'h02);
      acc(3'h2, 8'h15, 3'h0, 8'h00);
      acc(3'h5, 8'h15, 3'h0, 8'h00);
      rd(3'h1, 8'h15, 8'h04);
      cmp("timer0_flags", 8'h04, t0f);
      acc(3'h2, 8'h0b, 3'h0, 8'h81);
      acc(3'h5, 8'h0b, 3'h3, 8'h00);
      acc(3'h6, 8'h0b, 3'h7, 8'h00);
      cmp("port_d_output", 8'h09, pdo);
      for (int b = 0; b < 4; b++) begin
         acc(3'h7, 8'h0b, 3'(b), 8'h00);
         cmp("skip_next", {7'h0, (b == 0 || b == 3)}, {7'h0, sn});
      end
      acc(3'h2, 8'h2a, 3'h0, 8'h00);
      acc(3'h5, 8'h2a, 3'h0, 8'h00);
      rd(3'h1, 8'h2a, 8'h00);
      acc(3'h7, 8'h2a, 3'h0, 8'h00);
      cmp("skip_valid", 8'h00, {7'h0, sv});
      $display("test bit_access ended");
      acc(3'h4, 8'h80, 3'h0, 8'h3c);
      rd(3'h3, 8'h80, 8'h3c);
      rd(3'h1, 8'h80, 8'h00);
      $display("test extended ended");
      report_and_stop();
   end
endmodule
`default_nettype wire
